// ==== rtl/fp_cmp_mul_pkg.sv ====
package fp_cmp_mul_pkg;

    localparam int FLAG_W = 7;
    localparam int DEST_W = 7;

    localparam int DIV_ZERO_BIT = 0;
    localparam int INEXACT_BIT = 1;
    localparam int UNDERFLOW_BIT = 2;
    localparam int OVERFLOW_BIT = 3;
    localparam int BAD_OPERAND_BIT = 4;
    localparam int INPUT_FLUSH_BIT = 5;
    localparam int OUTPUT_FLUSH_BIT = 6;

    localparam logic [31:0] STATUS_ADDR = 32'h0000_0000;
    localparam int RM_LSB = 8;
    localparam int RM_W = 2;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'h0,
        RM_ZERO = 2'h1,
        RM_POS = 2'h2,
        RM_NEG = 2'h3
    } round_mode_t;

    localparam logic [7:0] EXP_ONES = 8'hff;
    localparam logic [9:0] EXP_BIAS = 10'h07f;
    localparam logic [9:0] EXP_TOP = 10'h0ff;
    localparam logic [9:0] FLUSH_FLOOR = 10'h3e8;
    localparam logic [31:0] QNAN_WORD = 32'hffff_ffff;
    localparam logic [30:0] INF_MAG = 31'h7f80_0000;
    localparam logic [30:0] MAX_MAG = 31'h7f7f_ffff;

    typedef struct packed {
        logic valid;
        logic flag_var;
        logic [31:0] guard;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [DEST_W-1:0] dest;
    } op_req_t;

    typedef struct packed {
        logic we;
        logic [31:0] data;
        logic [DEST_W-1:0] dest;
    } op_ans_t;

    typedef struct packed {
        logic en;
        logic flag_var;
        logic [DEST_W-1:0] dest;
        logic sign;
        logic nan_res;
        logic inf_res;
        logic zero_res;
        logic [47:0] prod;
        logic [9:0] exp;
        logic [FLAG_W-1:0] pre_flags;
        round_mode_t rm;
    } mul_s1_t;

    typedef struct packed {
        logic en;
        logic flag_var;
        logic [DEST_W-1:0] dest;
        logic [31:0] data;
        logic [FLAG_W-1:0] flags;
    } mul_s2_t;

endpackage

// ==== rtl/fp_less_compare_and_multiply.sv ====
// Contract
// - Guard LSB alone enables destination write.
// - False guard blocks write and status flags.
// - Compare writes 1 when first below second.
// - Compare exceptions set status word flags.
// - Compare flag form returns comparison exceptions.
// - Flag forms never touch status flags.
// - Flag vector follows status flag layout.
// - Compare flag form flushes denormals, sets input-flush.
// - Less-than flags equal swapped greater-than flags.
// - Multiply writes single-precision product.
// - Multiply rounds using status rounding mode.
// - Multiply flushes denormal inputs, sets input-flush.
// - Denormal product becomes zero, sets output-flush.
// - Multiply exceptions set status word flags.
// - Status flags sticky, cleared only by write.
// - Status flags update with destination write.
// - Simultaneous flag updates are OR-combined.
// - Multiply flag form reports product exceptions.
// - Multiply flag form sets output-flush on denormal.
// - Flag forms give integer, write on guard.
`timescale 1ns/1ns
module fp_less_compare_and_multiply (
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire fp_cmp_mul_pkg::op_req_t CMP_REQ_IN,
    input wire fp_cmp_mul_pkg::op_req_t MUL_REQ_IN,
    input wire logic [fp_cmp_mul_pkg::FLAG_W-1:0] EXT_FLAGS_IN,
    output fp_cmp_mul_pkg::op_ans_t CMP_ANS_OUT,
    output fp_cmp_mul_pkg::op_ans_t MUL_ANS_OUT,
    output logic [fp_cmp_mul_pkg::FLAG_W-1:0] STATUS_FLAGS_OUT
);

    typedef struct packed {
        fp_cmp_mul_pkg::op_ans_t cmp;
        fp_cmp_mul_pkg::mul_s1_t m1;
        fp_cmp_mul_pkg::mul_s2_t m2;
        fp_cmp_mul_pkg::op_ans_t mul;
        logic [fp_cmp_mul_pkg::FLAG_W-1:0] flags;
        fp_cmp_mul_pkg::round_mode_t rm;
        logic ahb_wr;
        logic ahb_hit;
        logic [31:0] hrdata;
        logic hready;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic is_denorm(input logic [31:0] v);
        is_denorm = (v[30:23] == 8'h00) && (v[22:0] != 23'h0);
    endfunction

    function automatic logic is_nan(input logic [31:0] v);
        is_nan = (v[30:23] == fp_cmp_mul_pkg::EXP_ONES) && (v[22:0] != 23'h0);
    endfunction

    function automatic logic is_inf(input logic [31:0] v);
        is_inf = (v[30:0] == fp_cmp_mul_pkg::INF_MAG);
    endfunction

    function automatic logic [31:0] flush(input logic [31:0] v);
        flush = is_denorm(v) ? {v[31], 31'h0} : v;
    endfunction

    // Result of a < b on flushed operands; unordered and equal give 0.
    function automatic logic less_than(input logic [31:0] a, input logic [31:0] b);
        logic r;
        r = 1'b0;
        if (is_nan(a) || is_nan(b))
        begin
            r = 1'b0;
        end
        else if ((a[30:0] == 31'h0) && (b[30:0] == 31'h0))
        begin
            r = 1'b0;
        end
        else if (a[31] != b[31])
        begin
            r = a[31];
        end
        else if (!a[31])
        begin
            r = a[30:0] < b[30:0];
        end
        else
        begin
            r = a[30:0] > b[30:0];
        end
        less_than = r;
    endfunction

    logic [31:0] cmp_a;
    logic [31:0] cmp_b;
    logic cmp_en;
    logic [fp_cmp_mul_pkg::FLAG_W-1:0] cmp_flags;
    logic [fp_cmp_mul_pkg::FLAG_W-1:0] cmp_upd;
    logic [31:0] mul_a;
    logic [31:0] mul_b;
    logic mul_zero_a;
    logic mul_zero_b;
    logic mul_inf_a;
    logic mul_inf_b;
    logic [23:0] mant_a;
    logic [23:0] mant_b;
    logic norm;
    logic [23:0] mant24;
    logic rnd_g;
    logic rnd_s;
    logic rnd_inc;
    logic [24:0] mant_r;
    logic [9:0] exp_n;
    logic [9:0] exp_r;
    logic [22:0] frac_r;
    logic to_inf;
    logic [31:0] s2_data;
    logic [fp_cmp_mul_pkg::FLAG_W-1:0] s2_flags;
    logic [fp_cmp_mul_pkg::FLAG_W-1:0] mul_upd;
    logic addr_take;
    logic bus_write;

    always_comb
    begin
        next_st = st;

        // Compare unit: denormals read as zero, NaN operands are invalid.
        cmp_a = flush(CMP_REQ_IN.src_a);
        cmp_b = flush(CMP_REQ_IN.src_b);
        cmp_en = CMP_REQ_IN.valid && CMP_REQ_IN.guard[0];
        cmp_flags = '0;
        cmp_flags[fp_cmp_mul_pkg::BAD_OPERAND_BIT] = is_nan(cmp_a) || is_nan(cmp_b);
        cmp_flags[fp_cmp_mul_pkg::INPUT_FLUSH_BIT] = is_denorm(CMP_REQ_IN.src_a)
            || is_denorm(CMP_REQ_IN.src_b);
        cmp_upd = (cmp_en && !CMP_REQ_IN.flag_var) ? cmp_flags : '0;
        next_st.cmp.we = cmp_en;
        if (cmp_en)
        begin
            next_st.cmp.dest = CMP_REQ_IN.dest;
            if (CMP_REQ_IN.flag_var)
            begin
                next_st.cmp.data = {25'h0, cmp_flags};
            end
            else
            begin
                next_st.cmp.data = {31'h0, less_than(cmp_a, cmp_b)};
            end
        end

        // Multiply stage 1: flush inputs, classify, form the mantissa product.
        mul_a = flush(MUL_REQ_IN.src_a);
        mul_b = flush(MUL_REQ_IN.src_b);
        mul_zero_a = (mul_a[30:0] == 31'h0);
        mul_zero_b = (mul_b[30:0] == 31'h0);
        mul_inf_a = is_inf(mul_a);
        mul_inf_b = is_inf(mul_b);
        mant_a = {1'b1, mul_a[22:0]};
        mant_b = {1'b1, mul_b[22:0]};
        next_st.m1.en = MUL_REQ_IN.valid && MUL_REQ_IN.guard[0];
        next_st.m1.flag_var = MUL_REQ_IN.flag_var;
        next_st.m1.dest = MUL_REQ_IN.dest;
        next_st.m1.sign = mul_a[31] ^ mul_b[31];
        next_st.m1.nan_res = is_nan(mul_a) || is_nan(mul_b)
            || (mul_inf_a && mul_zero_b) || (mul_zero_a && mul_inf_b);
        next_st.m1.inf_res = (mul_inf_a || mul_inf_b) && !next_st.m1.nan_res;
        next_st.m1.zero_res = (mul_zero_a || mul_zero_b) && !next_st.m1.nan_res;
        next_st.m1.prod = {24'h0, mant_a} * {24'h0, mant_b};
        next_st.m1.exp = {2'b00, mul_a[30:23]} + {2'b00, mul_b[30:23]}
            - fp_cmp_mul_pkg::EXP_BIAS;
        next_st.m1.pre_flags = '0;
        next_st.m1.pre_flags[fp_cmp_mul_pkg::BAD_OPERAND_BIT] = next_st.m1.nan_res;
        next_st.m1.pre_flags[fp_cmp_mul_pkg::INPUT_FLUSH_BIT] = is_denorm(MUL_REQ_IN.src_a)
            || is_denorm(MUL_REQ_IN.src_b);
        next_st.m1.rm = st.rm;

        // Multiply stage 2: normalise, round by the captured mode, classify.
        norm = st.m1.prod[47];
        mant24 = norm ? st.m1.prod[47:24] : st.m1.prod[46:23];
        rnd_g = norm ? st.m1.prod[23] : st.m1.prod[22];
        rnd_s = norm ? (|st.m1.prod[22:0]) : (|st.m1.prod[21:0]);
        case (st.m1.rm)
            fp_cmp_mul_pkg::RM_NEAREST: rnd_inc = rnd_g && (rnd_s || mant24[0]);
            fp_cmp_mul_pkg::RM_ZERO: rnd_inc = 1'b0;
            fp_cmp_mul_pkg::RM_POS: rnd_inc = (rnd_g || rnd_s) && !st.m1.sign;
            fp_cmp_mul_pkg::RM_NEG: rnd_inc = (rnd_g || rnd_s) && st.m1.sign;
            default: rnd_inc = 1'b0;
        endcase
        mant_r = {1'b0, mant24} + {24'h0, rnd_inc};
        exp_n = st.m1.exp + {9'h0, norm};
        exp_r = exp_n + {9'h0, mant_r[24]};
        frac_r = mant_r[24] ? mant_r[23:1] : mant_r[22:0];
        to_inf = (st.m1.rm == fp_cmp_mul_pkg::RM_NEAREST)
            || ((st.m1.rm == fp_cmp_mul_pkg::RM_POS) && !st.m1.sign)
            || ((st.m1.rm == fp_cmp_mul_pkg::RM_NEG) && st.m1.sign);
        s2_flags = st.m1.pre_flags;
        s2_data = {st.m1.sign, 31'h0};
        if (st.m1.nan_res)
        begin
            s2_data = fp_cmp_mul_pkg::QNAN_WORD;
        end
        else if (st.m1.inf_res)
        begin
            s2_data = {st.m1.sign, fp_cmp_mul_pkg::INF_MAG};
        end
        else if (st.m1.zero_res)
        begin
            s2_data = {st.m1.sign, 31'h0};
        end
        else if ($signed(exp_r) >= $signed(fp_cmp_mul_pkg::EXP_TOP))
        begin
            s2_data = {st.m1.sign, to_inf ? fp_cmp_mul_pkg::INF_MAG : fp_cmp_mul_pkg::MAX_MAG};
            s2_flags[fp_cmp_mul_pkg::OVERFLOW_BIT] = 1'b1;
            s2_flags[fp_cmp_mul_pkg::INEXACT_BIT] = 1'b1;
        end
        else if ($signed(exp_r) <= $signed(10'h000))
        begin
            // A product that would sit in the denormal range is flushed; one far
            // below it simply underflows to zero without the output-flush mark.
            s2_data = {st.m1.sign, 31'h0};
            s2_flags[fp_cmp_mul_pkg::UNDERFLOW_BIT] = 1'b1;
            s2_flags[fp_cmp_mul_pkg::INEXACT_BIT] = 1'b1;
            s2_flags[fp_cmp_mul_pkg::OUTPUT_FLUSH_BIT] =
                $signed(exp_r) > $signed(fp_cmp_mul_pkg::FLUSH_FLOOR);
        end
        else
        begin
            s2_data = {st.m1.sign, exp_r[7:0], frac_r};
            s2_flags[fp_cmp_mul_pkg::INEXACT_BIT] = rnd_g || rnd_s;
        end
        next_st.m2.en = st.m1.en;
        next_st.m2.flag_var = st.m1.flag_var;
        next_st.m2.dest = st.m1.dest;
        next_st.m2.data = s2_data;
        next_st.m2.flags = s2_flags;

        // Multiply stage 3: destination write and status update together.
        mul_upd = (st.m2.en && !st.m2.flag_var) ? st.m2.flags : '0;
        next_st.mul.we = st.m2.en;
        if (st.m2.en)
        begin
            next_st.mul.dest = st.m2.dest;
            next_st.mul.data = st.m2.flag_var ? {25'h0, st.m2.flags} : st.m2.data;
        end

        // Bus data phase write replaces the flags; new events are ORed on top
        // so that an event in the clearing cycle survives the clear.
        bus_write = st.ahb_wr && st.ahb_hit;
        next_st.flags = (bus_write ? HWDATA_IN[fp_cmp_mul_pkg::FLAG_W-1:0] : st.flags)
            | cmp_upd | mul_upd | EXT_FLAGS_IN;
        if (bus_write)
        begin
            next_st.rm = fp_cmp_mul_pkg::round_mode_t'(
                HWDATA_IN[fp_cmp_mul_pkg::RM_LSB +: fp_cmp_mul_pkg::RM_W]);
        end

        // Read data is taken from the next state so a read right after a
        // write already sees the written value.
        addr_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
        next_st.ahb_wr = addr_take && HWRITE_IN;
        next_st.ahb_hit = addr_take && (HADDR_IN == fp_cmp_mul_pkg::STATUS_ADDR);
        next_st.hrdata = 32'h0000_0000;
        if (addr_take && !HWRITE_IN && next_st.ahb_hit)
        begin
            next_st.hrdata[fp_cmp_mul_pkg::FLAG_W-1:0] = next_st.flags;
            next_st.hrdata[fp_cmp_mul_pkg::RM_LSB +: fp_cmp_mul_pkg::RM_W] = next_st.rm;
        end
        next_st.hready = 1'b1;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
        begin
            st <= '0;
            st.flags <= fp_cmp_mul_pkg::FLAGS_RESET;
            st.rm <= fp_cmp_mul_pkg::RM_NEAREST;
            st.hready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign HRDATA_OUT = st.hrdata;
    assign HREADYOUT_OUT = st.hready;
    assign HRESP_OUT = 1'b0;
    assign CMP_ANS_OUT = st.cmp;
    assign MUL_ANS_OUT = st.mul;
    assign STATUS_FLAGS_OUT = st.flags;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);

    cmp_guard_a: assert property (CMP_REQ_IN.valid && !CMP_REQ_IN.guard[0] |=>
        !CMP_ANS_OUT.we)
        else $error("Compare wrote with a false guard.");

    cmp_latency_a: assert property (CMP_REQ_IN.valid && CMP_REQ_IN.guard[0] |=>
        CMP_ANS_OUT.we && (CMP_ANS_OUT.dest == $past(CMP_REQ_IN.dest)))
        else $error("Compare result not written one cycle after issue.");

    mul_latency_a: assert property (MUL_REQ_IN.valid && MUL_REQ_IN.guard[0] |->
        ##3 MUL_ANS_OUT.we)
        else $error("Multiply result not written three cycles after issue.");

    mul_guard_a: assert property (MUL_REQ_IN.valid && !MUL_REQ_IN.guard[0] |->
        ##3 !MUL_ANS_OUT.we)
        else $error("Multiply wrote with a false guard.");

    flags_sticky_a: assert property (!(st.ahb_wr && st.ahb_hit) |=>
        ((STATUS_FLAGS_OUT & $past(STATUS_FLAGS_OUT)) == $past(STATUS_FLAGS_OUT)))
        else $error("Status flag dropped without a bus write.");

    ext_or_a: assert property (EXT_FLAGS_IN != '0 |=>
        ((STATUS_FLAGS_OUT & $past(EXT_FLAGS_IN)) == $past(EXT_FLAGS_IN)))
        else $error("Simultaneous flag update lost.");

    cmp_equal_a: assert property (cmp_en && !CMP_REQ_IN.flag_var
        && (CMP_REQ_IN.src_a == CMP_REQ_IN.src_b) |=> CMP_ANS_OUT.data == 32'h0)
        else $error("Equal operands compared as less.");

    cmp_flush_a: assert property (cmp_en && CMP_REQ_IN.flag_var
        && is_denorm(CMP_REQ_IN.src_a) |=>
        CMP_ANS_OUT.data[fp_cmp_mul_pkg::INPUT_FLUSH_BIT] && (CMP_ANS_OUT.data[31:7] == 25'h0))
        else $error("Compare flag form missed input flush.");

    flagvar_quiet_a: assert property (cmp_en && CMP_REQ_IN.flag_var
        && !MUL_ANS_OUT.we && (st.m2.en == 1'b0) && (EXT_FLAGS_IN == '0)
        && !(st.ahb_wr && st.ahb_hit) |=> STATUS_FLAGS_OUT == $past(STATUS_FLAGS_OUT))
        else $error("Compare flag form changed the status flags.");

    mul_flush_a: assert property (MUL_REQ_IN.valid && MUL_REQ_IN.guard[0]
        && !MUL_REQ_IN.flag_var && is_denorm(MUL_REQ_IN.src_a) && !is_inf(MUL_REQ_IN.src_b)
        && !is_nan(MUL_REQ_IN.src_b) |-> ##3 (MUL_ANS_OUT.data[30:0] == 31'h0)
        && STATUS_FLAGS_OUT[fp_cmp_mul_pkg::INPUT_FLUSH_BIT])
        else $error("Denormal multiply input not flushed.");

    cmp_nan_a: assert property (cmp_en && !CMP_REQ_IN.flag_var
        && (is_nan(cmp_a) || is_nan(cmp_b)) |=>
        STATUS_FLAGS_OUT[fp_cmp_mul_pkg::BAD_OPERAND_BIT] && (CMP_ANS_OUT.data == 32'h0))
        else $error("Compare with a NaN operand missed the invalid flag.");

    cmp_vector_a: assert property (cmp_en && CMP_REQ_IN.flag_var |=>
        CMP_ANS_OUT.we && (CMP_ANS_OUT.data[31:7] == 25'h0))
        else $error("Compare flag vector has bits above the flag field.");

    mul_vector_a: assert property (MUL_REQ_IN.valid && MUL_REQ_IN.guard[0]
        && MUL_REQ_IN.flag_var |-> ##3 MUL_ANS_OUT.we
        && (MUL_ANS_OUT.data[31:7] == 25'h0))
        else $error("Multiply flag vector has bits above the flag field.");

    mul_overflow_a: assert property (st.m2.en && !st.m2.flag_var
        && st.m2.flags[fp_cmp_mul_pkg::OVERFLOW_BIT] |=> MUL_ANS_OUT.we
        && STATUS_FLAGS_OUT[fp_cmp_mul_pkg::OVERFLOW_BIT])
        else $error("Multiply overflow not recorded with the write.");

    mul_tiny_a: assert property (st.m2.en && !st.m2.flag_var
        && st.m2.flags[fp_cmp_mul_pkg::OUTPUT_FLUSH_BIT] |=>
        (MUL_ANS_OUT.data[30:0] == 31'h0) && STATUS_FLAGS_OUT[fp_cmp_mul_pkg::OUTPUT_FLUSH_BIT])
        else $error("Flushed multiply result not zero or flag not set.");

endmodule // fp_less_compare_and_multiply

// ==== dv/fp_issue_model.sv ====
`timescale 1ns/1ns
module fp_issue_model (
    input wire logic clk_in,
    input wire fp_cmp_mul_pkg::op_ans_t cmp_ans_in,
    input wire fp_cmp_mul_pkg::op_ans_t mul_ans_in,
    input wire logic [6:0] status_in,
    output fp_cmp_mul_pkg::op_req_t cmp_req_out,
    output fp_cmp_mul_pkg::op_req_t mul_req_out,
    output logic [6:0] ext_out
);
    logic [31:0] regs [128];
    logic [6:0] st_we;
    int cyc = 0;
    int t_iss = 0;
    int lat = 0;
    int n_wr = 0;
    initial
    begin
        cmp_req_out = '0;
        mul_req_out = '0;
        ext_out = '0;
    end
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cmp_ans_in.we)
            regs[cmp_ans_in.dest] <= cmp_ans_in.data;
        if (mul_ans_in.we)
            regs[mul_ans_in.dest] <= mul_ans_in.data;
        if (cmp_ans_in.we || mul_ans_in.we)
        begin
            n_wr <= n_wr + 1;
            lat <= cyc - t_iss;
            st_we <= status_in;
        end
    end
    task automatic issue(input logic m, f, input logic [31:0] g, a, b,
        input logic [6:0] d, x);
        fp_cmp_mul_pkg::op_req_t r;
        fp_cmp_mul_pkg::op_req_t idle;
        r = '{1'b1, f, g, a, b, d};
        // Idle operands are inverted so a design that samples them late gets garbage.
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge clk_in);
        t_iss = cyc;
        if (m)
            mul_req_out <= r;
        else
            cmp_req_out <= r;
        ext_out <= x;
        @(posedge clk_in);
        if (m)
            mul_req_out <= idle;
        else
            cmp_req_out <= idle;
        ext_out <= '0;
    endtask
endmodule // fp_issue_model

// ==== dv/fp_less_compare_and_multiply_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module fp_less_compare_and_multiply_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready;
    logic hresp;
    fp_cmp_mul_pkg::op_req_t cmp_req;
    fp_cmp_mul_pkg::op_req_t mul_req;
    fp_cmp_mul_pkg::op_ans_t cmp_ans;
    fp_cmp_mul_pkg::op_ans_t mul_ans;
    logic [6:0] ext;
    logic [6:0] status;
    int miscompares = 0;
    int n_tests = 0;
    logic [71:0] ct [10] = '{{32'h40400000, 32'h0, 8'h00}, {32'h40400000, 32'h40400000, 8'h00},
        {32'h3f800000, 32'h40400000, 8'h80}, {32'h40400000, 32'h3f800000, 8'h00},
        {32'h40400000, 32'hffffffff, 8'h10}, {32'h7f800000, 32'hff800000, 8'h00},
        {32'h3f800000, 32'h00400000, 8'h20}, {32'h7f800000, 32'h7f800000, 8'h00},
        {32'h80000000, 32'h0, 8'h00}, {32'h00400000, 32'h3f800000, 8'ha0}};
    logic [103:0] mt [10] = '{{32'hc0400000, 32'h3f800000, 32'hc0400000, 8'h00},
        {32'h40400000, 32'hc0400000, 32'hc1100000, 8'h00},
        {32'h40400000, 32'h00800000, 32'h01400000, 8'h00},
        {32'h3f000000, 32'h00800000, 32'h0, 8'h46}, {32'h7f800000, 32'h0, 32'hffffffff, 8'h10},
        {32'h40400000, 32'h00400000, 32'h0, 8'h20}, {32'h00800000, 32'h00800000, 32'h0, 8'h06},
        {32'h7f800000, 32'hff800000, 32'hff800000, 8'h00},
        {32'h7f7fffff, 32'h7f7fffff, 32'h7f800000, 8'h0a},
        {32'h00400000, 32'h40400000, 32'h0, 8'h20}};
    always #2 clk = ~clk;
    fp_less_compare_and_multiply dut (.MCLK_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .CMP_REQ_IN(cmp_req), .MUL_REQ_IN(mul_req), .EXT_FLAGS_IN(ext),
        .CMP_ANS_OUT(cmp_ans), .MUL_ANS_OUT(mul_ans), .STATUS_FLAGS_OUT(status));
    fp_issue_model pm (.clk_in(clk), .cmp_ans_in(cmp_ans), .mul_ans_in(mul_ans),
        .status_in(status), .cmp_req_out(cmp_req), .mul_req_out(mul_req), .ext_out(ext));
    task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        `CHK("hresp", 1'b0, hresp)
        hsel <= 1'b0;
    endtask
    task automatic run(input logic m, f, input logic [31:0] g, a, b, input logic [6:0] x,
        input logic [31:0] er, input logic [6:0] es);
        int n0;
        int k;
        n0 = pm.n_wr;
        pm.regs[5] = 32'h5a5a_5a5a;
        pm.issue(m, f, g, a, b, 7'h05, x);
        k = 0;
        while (pm.n_wr == n0 && k < 8)
        begin
            @(posedge clk);
            k++;
        end
        `CHK("dest", er, pm.regs[5])
        `CHK("status", es, status)
        if (g[0])
        begin
            // The model sees the write one edge after the design takes its answer.
            `CHK("latency", m ? 4 : 2, pm.lat)
            `CHK("status at write", es, pm.st_we)
        end
    endtask
    task automatic t_guard();
        bus(1'b1, 32'h0, 32'h0, rd);
        run(1'b0, 1'b0, 32'h0, 32'h3f800000, 32'h40400000, 7'h0, 32'h5a5a_5a5a, 7'h0);
        run(1'b0, 1'b0, 32'h2, 32'h3f800000, 32'hffffffff, 7'h0, 32'h5a5a_5a5a, 7'h0);
        run(1'b1, 1'b0, 32'h0, 32'h7f800000, 32'h0, 7'h0, 32'h5a5a_5a5a, 7'h0);
        run(1'b1, 1'b1, 32'h0, 32'h7f800000, 32'h0, 7'h0, 32'h5a5a_5a5a, 7'h0);
        run(1'b0, 1'b0, 32'h3, 32'h3f800000, 32'h40400000, 7'h0, 32'h1, 7'h0);
        $display("t_guard done");
    endtask
    task automatic t_cmp();
        logic [31:0] a;
        logic [31:0] b;
        logic [7:0] e;
        for (int i = 0; i < 10; i++)
        begin
            {a, b, e} = ct[i];
            bus(1'b1, 32'h0, 32'h0, rd);
            run(1'b0, 1'b1, 32'h1, a, b, 7'h0, {25'h0, e[6:0]}, 7'h0);
            run(1'b0, 1'b1, 32'h1, b, a, 7'h0, {25'h0, e[6:0]}, 7'h0);
            run(1'b0, 1'b0, 32'h1, a, b, 7'h0, {31'h0, e[7]}, e[6:0]);
        end
        $display("t_cmp done");
    endtask
    task automatic t_mul();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        logic [7:0] e;
        for (int i = 0; i < 10; i++)
        begin
            {a, b, r, e} = mt[i];
            bus(1'b1, 32'h0, 32'h0, rd);
            run(1'b1, 1'b1, 32'h1, a, b, 7'h0, {25'h0, e[6:0]}, 7'h0);
            run(1'b1, 1'b0, 32'h1, a, b, 7'h0, r, e[6:0]);
        end
        $display("t_mul done");
    endtask
    task automatic t_round();
        bus(1'b1, 32'h0, 32'h100, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK("status word", 32'h100, rd)
        bus(1'b0, 32'h4, 32'h0, rd);
        `CHK("unmapped read", 32'h0, rd)
        run(1'b1, 1'b1, 32'h1, 32'h7f7fffff, 32'h7f7fffff, 7'h0, 32'h0a, 7'h0);
        run(1'b1, 1'b0, 32'h1, 32'h7f7fffff, 32'h7f7fffff, 7'h0, 32'h7f7fffff, 7'h0a);
        bus(1'b1, 32'h0, 32'h0, rd);
        $display("t_round done");
    endtask
    task automatic t_sticky();
        bus(1'b1, 32'h0, 32'h0, rd);
        run(1'b0, 1'b0, 32'h1, 32'h40400000, 32'hffffffff, 7'h01, 32'h0, 7'h11);
        run(1'b0, 1'b0, 32'h1, 32'h40400000, 32'h3f800000, 7'h0, 32'h0, 7'h11);
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK("status word", 32'h11, rd)
        bus(1'b1, 32'h0, 32'h0, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK("status cleared", 32'h0, rd)
        $display("t_sticky done");
    endtask
    task automatic conclude();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("status reset", 7'h00, status)
        `CHK("hready", 1'b1, hready)
        t_guard();
        t_cmp();
        t_mul();
        t_round();
        t_sticky();
        conclude();
    end
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule // fp_less_compare_and_multiply_tb_top
